/* File: bench/see_host_model.sv */
/*
 * Behavioural SPI host that drives the serial memory pins and reads SO back.
 * Assumes the bench calls its tasks and that clk is the 20 MHz system clock.
 */
`timescale 1ns/10ps

module see_host_model (
   input wire logic clk, // System clock
   input wire logic so, // Serial data from the device
   input wire logic so_oe_n, // Low while the device drives so
   output see_pkg::see_pins_type pins, // Pins to the device
   output logic [7:0] rd_data, // Byte seen on so
   output logic rd_stb // Pulse: rd_data new
);
   import see_pkg::*;
   logic last_so = 1'h0;
   // A floated line shows the inverse of its last level, so a float never passes
   wire logic so_line = (so_oe_n === 1'h0) ? so : ~last_so;

   initial begin
      pins = '{cs_n: 1'h1, sck: 1'h0, si: 1'h0, wp_n: 1'h1, hold_n: 1'h1};
      rd_data = 8'h00;
      rd_stb = 1'h0;
   end

   always @(posedge clk) begin
      if (so_oe_n === 1'h0) last_so <= so;
   end

   // ************************************************************
   // Pin sequences; sck idles low between frames
   // ************************************************************
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic select();
      pins.cs_n = 1'h0;
      step(5);
   endtask : select

   task automatic deselect();
      step(4);
      pins.cs_n = 1'h1;
      step(6);
   endtask : deselect

   // Bits hi down to lo of tx; so is taken just before each rising sck
   task automatic send_bits(input logic [7:0] tx, input int hi, input int lo, input logic rd);
      logic [7:0] got;
      got = 8'h00;
      for (int i = hi; i >= lo; i--) begin
         pins.si = tx[i];
         step(4);
         got = {got[6:0], so_line};
         pins.sck = 1'h1;
         step(4);
         pins.sck = 1'h0;
      end
      if (rd) begin
         rd_data = got;
         rd_stb = 1'h1;
         step(1);
         rd_stb = 1'h0;
      end
   endtask : send_bits
endmodule : see_host_model

/* File: bench/test_see_top.sv */
/*
 * Self-checking bench of see_top: host model on the pins, bench on the user side.
 * Assumes see_pkg and see_map.svh are compiled first.
 */
`timescale 1ns/10ps

module test_see_top;
   import see_pkg::*;
   localparam int WC = 20;
   localparam int DEPTH = 16;
   logic CLK, RST, SO, SO_OE_N, RX_VALID, TX_VALID, TX_READY, TX_EN, WR_SEQ_OK;
   logic WEL_SET, WEL_CLR, WEL, BUSY, STANDBY, WRITE_START, rd_stb;
   logic [7:0] TX_DATA, rd_data;
   logic [31:0] lfsr;
   see_pins_type PINS;
   see_rx_type RX;
   see_rx_type rx_q[$];
   logic [7:0] rd_q[$];
   int fails, comparisons, ws_count, busy_run, last_busy;

   see_top #(.WC_CYCLES(WC), .FIFO_DEPTH(DEPTH)) uut (.CLK(CLK), .RST(RST), .PINS(PINS),
      .SO(SO), .SO_OE_N(SO_OE_N), .RX(RX), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA),
      .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_EN(TX_EN), .WR_SEQ_OK(WR_SEQ_OK),
      .WEL_SET(WEL_SET), .WEL_CLR(WEL_CLR), .WEL(WEL), .BUSY(BUSY), .STANDBY(STANDBY),
      .WRITE_START(WRITE_START));
   see_host_model host (.clk(CLK), .so(SO), .so_oe_n(SO_OE_N), .pins(PINS),
      .rd_data(rd_data), .rd_stb(rd_stb));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic final_report();
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   function automatic logic [7:0] rand8();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rand8

   task automatic pulse(input logic set);
      if (set) WEL_SET = 1'h1;
      else WEL_CLR = 1'h1;
      host.step(1);
      WEL_SET = 1'h0;
      WEL_CLR = 1'h0;
      host.step(2);
   endtask : pulse

   task automatic rx_byte(input logic first, input logic rd);
      logic [7:0] b;
      b = rand8();
      rx_q.push_back('{first, b});
      host.send_bits(b, 7, 0, rd);
   endtask : rx_byte

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic pause_run();
      logic [7:0] b;
      b = rand8();
      TX_EN = 1'h1;
      host.select();
      rx_q.push_back('{1'h1, b});
      host.send_bits(b, 7, 5, 1'h0);
      check("SO_OE_N reading", 0, SO_OE_N);
      host.pins.hold_n = 1'h0;
      host.step(3);
      check("SO_OE_N paused", 1, SO_OE_N);
      host.send_bits(~b, 7, 6, 1'h0);
      host.pins.sck = 1'h1;
      host.pins.hold_n = 1'h1;
      host.step(4);
      host.pins.sck = 1'h0;
      host.send_bits(~b, 7, 6, 1'h0);
      host.pins.hold_n = 1'h0;
      host.step(4);
      host.pins.hold_n = 1'h1;
      host.step(4);
      check("STANDBY paused", 0, STANDBY);
      host.pins.si = b[4];
      host.step(4);
      host.pins.sck = 1'h1;
      host.step(2);
      host.pins.hold_n = 1'h0;
      host.step(3);
      check("SO_OE_N pause clock high", 1, SO_OE_N);
      host.pins.sck = 1'h0;
      host.step(4);
      host.pins.hold_n = 1'h1;
      host.step(4);
      host.send_bits(b, 3, 0, 1'h0);
      host.deselect();
      TX_EN = 1'h0;
   endtask : pause_run

   task automatic read_run();
      int taken;
      logic t;
      taken = 0;
      TX_VALID = 1'h1;
      TX_DATA = rand8();
      for (int i = 0; i < DEPTH + 4; i++) begin
         t = (TX_READY === 1'h1);
         if (t) rd_q.push_back(TX_DATA);
         host.step(1);
         if (t) begin
            taken++;
            TX_DATA = rand8();
         end
      end
      TX_VALID = 1'h0;
      check("fifo words taken", DEPTH, taken);
      check("TX_READY full", 0, TX_READY);
      rd_q.push_back(8'hFF);
      TX_EN = 1'h1;
      host.select();
      rx_byte(1'h1, 1'h0);
      for (int i = 0; i <= DEPTH; i++) rx_byte(1'h0, 1'h1);
      host.deselect();
      TX_EN = 1'h0;
      check("SO_OE_N after read", 1, SO_OE_N);
      check("TX_READY drained", 1, TX_READY);
   endtask : read_run

   // extra: bits after the last whole byte; drop: lower write protect mid-cycle
   task automatic do_write(input int extra, input logic drop);
      int ws0;
      ws0 = ws_count;
      pulse(1'h1);
      check("WEL set", 1, WEL);
      host.select();
      rx_byte(1'h1, 1'h0);
      if (extra > 0) host.send_bits(rand8(), 7, 8 - extra, 1'h0);
      WR_SEQ_OK = 1'h1;
      host.deselect();
      if (drop) host.pins.wp_n = 1'h0;
      check("BUSY after select rise", extra == 0, BUSY);
      check("STANDBY during cycle", extra != 0, STANDBY);
      host.step(WC + 10);
      WR_SEQ_OK = 1'h0;
      host.pins.wp_n = 1'h1;
      check("write starts", extra == 0, ws_count - ws0);
      if (extra == 0) check("write cycle length", WC, last_busy);
      check("WEL after write", extra != 0, WEL);
      check("STANDBY after write", 1, STANDBY);
      host.step(4);
   endtask : do_write

   // ************************************************************
   // Clock, monitors, watchdog, main sequence
   // ************************************************************
   initial begin
      CLK = 1'h0;
      forever #25 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      if (WRITE_START === 1'h1) ws_count++;
      busy_run = (BUSY === 1'h1) ? busy_run + 1 : 0;
      if (BUSY === 1'h1) last_busy = busy_run;
      if (RX_VALID === 1'h1) begin
         if (rx_q.size() == 0) check("unexpected RX_VALID", 0, 1);
         else check("RX", rx_q.pop_front(), RX);
      end
      if (rd_stb === 1'h1) begin
         if (rd_q.size() == 0) check("unexpected read byte", 0, 1);
         else check("read byte", rd_q.pop_front(), rd_data);
      end
   end

   initial begin
      repeat (40000) @(posedge CLK);
      fails++;
      final_report();
   end

   initial begin
      {RST, TX_VALID, TX_EN, WR_SEQ_OK, WEL_SET, WEL_CLR} = 6'h20;
      TX_DATA = 8'h00;
      lfsr = 32'h90A1;
      {fails, comparisons, ws_count, busy_run, last_busy} = '0;
      // Random inputs during reset must leave SO_OE_N, STANDBY, WEL, BUSY, WRITE_START and RX_VALID at their reset levels
      repeat (7) begin
         host.step(1);
         void'(rand8());
         {TX_VALID, TX_EN, WR_SEQ_OK, WEL_SET, WEL_CLR} = lfsr[4:0];
         host.pins = lfsr[9:5];
      end
      host.step(1);
      {TX_VALID, TX_EN, WR_SEQ_OK, WEL_SET, WEL_CLR} = 5'h00;
      host.pins = '{cs_n: 1'h1, sck: 1'h0, si: 1'h0, wp_n: 1'h1, hold_n: 1'h1};
      check("reset SO_OE_N", 1, SO_OE_N);
      check("reset STANDBY", 1, STANDBY);
      check("reset WEL BUSY", 0, {WEL, BUSY, WRITE_START, RX_VALID});
      RST = 1'h0;
      host.step(4);
      host.select();
      check("STANDBY selected", 0, STANDBY);
      rx_byte(1'h1, 1'h0);
      rx_byte(1'h0, 1'h0);
      host.send_bits(rand8(), 7, 3, 1'h0);
      host.deselect();
      check("SO_OE_N deselected", 1, SO_OE_N);
      check("STANDBY deselected", 1, STANDBY);
      host.send_bits(rand8(), 7, 4, 1'h0);
      host.select();
      rx_byte(1'h1, 1'h0);
      host.deselect();
      pause_run();
      read_run();
      do_write(0, 1'h0);
      do_write(0, 1'h1);
      do_write(3, 1'h0);
      host.pins.wp_n = 1'h0;
      host.step(4);
      check("WEL cleared by protect", 0, WEL);
      pulse(1'h1);
      check("WEL set under protect", 0, WEL);
      host.pins.wp_n = 1'h1;
      host.step(4);
      pulse(1'h1);
      pulse(1'h0);
      check("WEL cleared", 0, WEL);
      host.step(10);
      check("pending notes", 0, rx_q.size() + rd_q.size());
      final_report();
   end
endmodule : test_see_top

/* File: rtl/see_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides and a registered ready flag.
 * Assumes a single clock; DEPTH is a power of two.
 */
`timescale 1ns/10ps

module see_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, high
   input wire logic in_valid, // Producer offers a word
   input wire logic [W-1:0] in_data, // Word offered
   output logic in_ready, // Room for a word
   output logic out_valid, // Word available
   output logic [W-1:0] out_data, // Oldest word
   input wire logic out_ready // Consumer takes the word
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic ready_reg;
   logic push;
   logic pop;

   assign push = in_valid & ready_reg;
   assign pop = out_valid & out_ready;
   assign in_ready = ready_reg;
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b1;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg <= count_next;
         ready_reg <= (count_next != (AW+1)'(DEPTH));
      end
   end
endmodule : see_fifo

/* File: rtl/see_sync.sv */
/*
 * Two-stage synchroniser for a group of asynchronous pin levels.
 * Assumes inputs change freely with respect to clk.
 */
`timescale 1ns/10ps

module see_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, high
   input wire logic [W-1:0] async_in, // Raw pin levels
   output logic [W-1:0] sync_out // Levels safe to read
);
   logic [W-1:0] meta_reg;

   // The first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : see_sync

/* File: rtl/see_top.sv */
/*
 * Pin-side logic of a serial memory: select, bit shifting, pause,
 * write protection, write enable latch and the self-timed write cycle.
 * Assumes an instruction decoder on the user side that classifies
 * sequences and supplies read bytes through the transmit FIFO.
 */
`timescale 1ns/10ps
`include "see_map.svh"

// Behaviour
// - Low select selects; high select means standby
// - Running write cycle completes; standby waits for it
// - Deselected device floats serial output
// - Select rising after valid write starts cycle
// - Write cycle ends within 5 ms
// - Input bits captured on clock rising edges
// - Output changes only after clock falling edges
// - Write protect low blocks all writes
// - Write protect low clears enable latch
// - Pause mid-sequence suspends, keeps sequence state
// - Pause falling with clock high waits
// - Paused device ignores clock, input; floats output
// - Resume only when pause rises, clock low
// - Pause low floats output at once
// - All fields shifted most significant bit first
// - First bit on first rise; resume continues
// - Write valid only on byte boundary
module see_top #(
   parameter int WC_CYCLES = `SEE_WC_CYCLES,
   parameter int FIFO_DEPTH = `SEE_FIFO_DEPTH
) (
   input wire logic CLK, // 20 MHz system clock
   input wire logic RST, // Synchronous reset, high
   input see_pkg::see_pins_type PINS, // Raw serial pins
   output logic SO, // Serial data out
   output logic SO_OE_N, // Serial out enable, low drives
   output see_pkg::see_rx_type RX, // Received byte
   output logic RX_VALID, // Pulse: RX holds a new byte
   input wire logic [`SEE_BYTE_W-1:0] TX_DATA, // Read byte offered
   input wire logic TX_VALID, // TX_DATA valid
   output logic TX_READY, // FIFO can take TX_DATA
   input wire logic TX_EN, // Decoder is in a read phase
   input wire logic WR_SEQ_OK, // Decoder: sequence is a complete write
   input wire logic WEL_SET, // Pulse: enable instruction done
   input wire logic WEL_CLR, // Pulse: disable instruction done
   output logic WEL, // Write enable latch
   output logic BUSY, // Internal write cycle running
   output logic STANDBY, // Deselected and idle
   output logic WRITE_START // Pulse: write cycle starts
);
   import see_pkg::*;

   localparam int WC_W = $clog2(WC_CYCLES + 1);

   // ************************************************************
   // Edge helpers
   // ************************************************************
   function automatic logic rose(input logic now, input logic was);
      rose = now & ~was;
   endfunction : rose

   function automatic logic fell(input logic now, input logic was);
      fell = ~now & was;
   endfunction : fell

   // ************************************************************
   // Pin synchronisation
   // ************************************************************
   see_pins_type pins_s;
   logic sck_d_reg;
   logic hold_d_reg;
   logic cs_d_reg;

   see_sync #(
      .W($bits(see_pins_type)),
      .INIT(`SEE_PINS_IDLE) // Rest levels, so no false clock edge follows reset
   ) u_sync (
      .clk(CLK),
      .rst(RST),
      .async_in(PINS),
      .sync_out(pins_s)
   );

   always_ff @(posedge CLK) begin
      if (RST) begin
         sck_d_reg <= 1'b0;
         hold_d_reg <= 1'b1;
         cs_d_reg <= 1'b1;
      end else begin
         sck_d_reg <= pins_s.sck;
         hold_d_reg <= pins_s.hold_n;
         cs_d_reg <= pins_s.cs_n;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic hold_rise;
   logic cs_rise;

   assign sck_rise = rose(pins_s.sck, sck_d_reg);
   assign sck_fall = fell(pins_s.sck, sck_d_reg);
   assign hold_rise = rose(pins_s.hold_n, hold_d_reg);
   assign cs_rise = rose(pins_s.cs_n, cs_d_reg);

   // ************************************************************
   // Select and pause state
   // ************************************************************
   see_link_state_type state_reg;
   see_link_state_type state_next;
   logic started_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LS_DESEL: begin
            if (!pins_s.cs_n) begin
               state_next = LS_ACTIVE;
            end
         end
         LS_ACTIVE: begin
            if (!pins_s.hold_n && started_reg) begin
               // A pause asked with the clock high waits for the fall
               state_next = pins_s.sck ? LS_PAUSE_WAIT : LS_PAUSED;
            end
         end
         LS_PAUSE_WAIT: begin
            if (pins_s.hold_n) begin
               state_next = LS_ACTIVE;
            end else if (sck_fall) begin
               state_next = LS_PAUSED;
            end
         end
         LS_PAUSED: begin
            if (hold_rise && !pins_s.sck) begin
               state_next = LS_ACTIVE;
            end
         end
      endcase
      if (pins_s.cs_n) begin
         state_next = LS_DESEL;
      end
   end

   // ************************************************************
   // Shifting
   // ************************************************************
   logic shift_ok;
   logic rx_take;
   logic tx_step;
   logic tx_load;
   logic tx_have;
   logic [`SEE_BYTE_W-1:0] tx_word;
   logic [`SEE_BYTE_W-1:0] fifo_data;
   logic [`SEE_BITCNT_W-1:0] bit_cnt_reg;
   logic [`SEE_BYTE_W-1:0] rx_sh_reg;
   logic [`SEE_BYTE_W-1:0] tx_sh_reg;
   logic first_reg;

   // Clock edges count only while selected and not paused
   assign shift_ok = (state_reg == LS_ACTIVE) && !pins_s.cs_n;
   assign rx_take = shift_ok & sck_rise;
   assign tx_step = shift_ok & sck_fall & TX_EN;
   assign tx_load = tx_step & (bit_cnt_reg == `SEE_BIT_ZERO);
   // An empty FIFO at a byte boundary sends idle ones rather than stale data
   assign tx_word = tx_have ? fifo_data : `SEE_TX_IDLE;

   see_fifo #(
      .W(`SEE_BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk(CLK),
      .rst(RST),
      .in_valid(TX_VALID),
      .in_data(TX_DATA),
      .in_ready(TX_READY),
      .out_valid(tx_have),
      .out_data(fifo_data),
      .out_ready(tx_load)
   );

   always_ff @(posedge CLK) begin
      if (RST || state_reg == LS_DESEL) begin
         bit_cnt_reg <= `SEE_BIT_ZERO;
         started_reg <= 1'b0;
         first_reg <= 1'b1;
         rx_sh_reg <= '0;
      end else if (rx_take) begin
         bit_cnt_reg <= bit_cnt_reg + `SEE_BIT_ONE;
         started_reg <= 1'b1;
         rx_sh_reg <= {rx_sh_reg[`SEE_BYTE_W-2:0], pins_s.si};
         if (bit_cnt_reg == `SEE_BIT_LAST) begin
            first_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RX <= '0;
         RX_VALID <= 1'b0;
      end else begin
         RX_VALID <= rx_take && (bit_cnt_reg == `SEE_BIT_LAST);
         if (rx_take && (bit_cnt_reg == `SEE_BIT_LAST)) begin
            RX <= '{first: first_reg, data: {rx_sh_reg[`SEE_BYTE_W-2:0], pins_s.si}};
         end
      end
   end

   // ************************************************************
   // Serial output
   // ************************************************************
   logic so_drive;

   // Pause low or deselect floats at once, whatever the clock phase
   assign so_drive = shift_ok && pins_s.hold_n && TX_EN;

   always_ff @(posedge CLK) begin
      if (RST) begin
         SO <= 1'b1;
         SO_OE_N <= `SEE_OE_OFF;
         tx_sh_reg <= `SEE_TX_IDLE;
      end else begin
         SO_OE_N <= so_drive ? `SEE_OE_ON : `SEE_OE_OFF;
         if (tx_load) begin
            SO <= tx_word[`SEE_BYTE_W-1];
            tx_sh_reg <= {tx_word[`SEE_BYTE_W-2:0], 1'b1};
         end else if (tx_step) begin
            SO <= tx_sh_reg[`SEE_BYTE_W-1];
            tx_sh_reg <= {tx_sh_reg[`SEE_BYTE_W-2:0], 1'b1};
         end
      end
   end

   // ************************************************************
   // Write enable latch and write cycle
   // ************************************************************
   logic write_go;
   logic wc_done;
   logic [WC_W-1:0] wc_cnt_reg;

   // The host relies on a select low before any sequence; edges before it are dropped
   assign write_go = cs_rise && started_reg && (bit_cnt_reg == `SEE_BIT_ZERO)
                     && WR_SEQ_OK && WEL && pins_s.wp_n && !BUSY;
   assign wc_done = BUSY && (wc_cnt_reg == '0);

   always_ff @(posedge CLK) begin
      if (RST) begin
         BUSY <= 1'b0;
         wc_cnt_reg <= '0;
         WRITE_START <= 1'b0;
      end else begin
         WRITE_START <= write_go;
         if (write_go) begin
            BUSY <= 1'b1;
            wc_cnt_reg <= WC_W'(WC_CYCLES - 1);
         end else if (wc_done) begin
            BUSY <= 1'b0;
         end else if (BUSY) begin
            wc_cnt_reg <= wc_cnt_reg - WC_W'(1);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         WEL <= 1'b0;
      end else if (!pins_s.wp_n || wc_done || WEL_CLR) begin
         WEL <= 1'b0;
      end else if (WEL_SET) begin
         WEL <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= LS_DESEL;
         STANDBY <= 1'b1;
      end else begin
         state_reg <= state_next;
         STANDBY <= pins_s.cs_n && !(BUSY && !wc_done) && !write_go;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic [WC_W:0] busy_age_reg;

   always_ff @(posedge CLK) begin
      if (RST || !BUSY) begin
         busy_age_reg <= '0;
      end else begin
         busy_age_reg <= busy_age_reg + (WC_W+1)'(1);
      end
   end

   property p_desel_float;
      @(posedge CLK) disable iff (RST) pins_s.cs_n |=> SO_OE_N;
   endproperty
   a_desel_float: assert property (p_desel_float) else $error("output driven while deselected");

   property p_pause_float;
      @(posedge CLK) disable iff (RST) !pins_s.hold_n |=> SO_OE_N;
   endproperty
   a_pause_float: assert property (p_pause_float) else $error("output driven while pause low");

   property p_wc_bound;
      @(posedge CLK) disable iff (RST) BUSY |-> busy_age_reg < (WC_W+1)'(WC_CYCLES);
   endproperty
   a_wc_bound: assert property (p_wc_bound) else $error("write cycle too long");

   property p_start_busy;
      @(posedge CLK) disable iff (RST) write_go |=> BUSY ##1 BUSY;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("write start without busy");

   property p_wp_clears;
      @(posedge CLK) disable iff (RST) !pins_s.wp_n |=> !WEL && !WRITE_START;
   endproperty
   a_wp_clears: assert property (p_wp_clears) else $error("write enabled under protect");

   property p_standby_idle;
      @(posedge CLK) disable iff (RST) STANDBY |-> !BUSY || $past(wc_done);
   endproperty
   a_standby_idle: assert property (p_standby_idle) else $error("standby during write");

   property p_rx_count;
      @(posedge CLK) disable iff (RST)
         rx_take |=> bit_cnt_reg == $past(bit_cnt_reg) + `SEE_BIT_ONE;
   endproperty
   a_rx_count: assert property (p_rx_count) else $error("bit count missed a rising edge");

   property p_so_edge;
      @(posedge CLK) disable iff (RST) $changed(SO) |-> $past(sck_fall);
   endproperty
   a_so_edge: assert property (p_so_edge) else $error("output changed off a falling edge");

   property p_pause_keep;
      @(posedge CLK) disable iff (RST)
         (state_reg == LS_PAUSED && !pins_s.cs_n) |=> $stable(bit_cnt_reg);
   endproperty
   a_pause_keep: assert property (p_pause_keep) else $error("sequence moved while paused");

   property p_no_resume_high;
      @(posedge CLK) disable iff (RST)
         (state_reg == LS_PAUSED && hold_rise && pins_s.sck && !pins_s.cs_n)
         |=> state_reg == LS_PAUSED;
   endproperty
   a_no_resume_high: assert property (p_no_resume_high) else $error("resumed with clock high");

   property p_desel_restart;
      @(posedge CLK) disable iff (RST) state_reg == LS_DESEL |=> bit_cnt_reg == `SEE_BIT_ZERO;
   endproperty
   a_desel_restart: assert property (p_desel_restart) else $error("bit count kept across select");

endmodule : see_top

/* File: shared/see_map.svh */
/*
 * Constants of the serial memory pin interface: timing, widths, codes.
 * Assumes inclusion by bare name from every file that needs a figure.
 */
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define SEE_CLK_HZ 20000000
`define SEE_WC_TIME_MS 5
`define SEE_WC_CYCLES (`SEE_WC_TIME_MS * (`SEE_CLK_HZ / 1000))

// ************************************************************
// Serial framing and pin codes
// ************************************************************
`define SEE_BYTE_W 8
`define SEE_BITCNT_W 3
`define SEE_BIT_ZERO 3'h0
`define SEE_BIT_ONE 3'h1
`define SEE_BIT_LAST 3'h7
`define SEE_TX_IDLE 8'hFF
`define SEE_FIFO_DEPTH 16
`define SEE_OE_ON 1'b0
`define SEE_OE_OFF 1'b1
// Pins at rest: deselected, clock low, protect and pause high
`define SEE_PINS_IDLE 5'h13

`endif

/* File: shared/see_pkg.sv */
/*
 * Types shared by the serial memory pin interface modules.
 * Assumes see_map.svh supplies the widths.
 */
`include "see_map.svh"

package see_pkg;

   // ************************************************************
   // Pin bundle and received byte
   // ************************************************************
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp_n;
      logic hold_n;
   } see_pins_type;

   typedef struct packed {
      logic first;
      logic [`SEE_BYTE_W-1:0] data;
   } see_rx_type;

   typedef enum logic [1:0] {
      LS_DESEL = 2'b00,
      LS_ACTIVE = 2'b01,
      LS_PAUSE_WAIT = 2'b10,
      LS_PAUSED = 2'b11
   } see_link_state_type;

endpackage : see_pkg
